//--- rtl/rtscmd_top.sv
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "rtscmd_params.svh"
module rtscmd_top import rtscmd_pkg::*; #(
	parameter int unsigned ONE_SEC_CYC =
		`RTS_ONE_SEC_MS * (`RTS_CLK_HZ / 1000)
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire rtscmd_rows_t rows,
	input wire logic [7:0] fp_target_set,
	input wire logic tgt_reset_btn,
	input wire logic [1:0] port_timed_out,
	input wire logic xtal_sec_tick,
	input wire logic irig_valid,
	input wire rtscmd_time_t irig_time,
	input wire logic st_we,
	input wire logic [3:0] st_addr,
	input wire logic [15:0] st_data,
	input wire logic set_byte_valid,
	input wire logic [7:0] set_byte,
	input wire logic set_end,
	input wire logic line_ready,
	output logic line_valid,
	output rtscmd_line_t line,
	output logic [7:0] target_led,
	output logic alarm_contact,
	output logic event_trig
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_sep(input logic [6:0] c);
		is_sep = (c == `RTS_SEP_COLON) || (c == `RTS_SEP_SEMI) ||
			(c == `RTS_SEP_SPACE) || (c == `RTS_SEP_COMMA) ||
			(c == `RTS_SEP_SLASH);
	endfunction : is_sep

	// bits pass straight through: 1 asserted, 0 deasserted
	function automatic logic [7:0] row_pick(input rtscmd_rows_t r,
		input logic [3:0] lvl, input logic [7:0] t0);
		case (lvl)
			4'h0: row_pick = t0;
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
				row_pick = r.relay_word[3'(lvl - 4'h1)];
			end
			4'h7: row_pick = {2'h0, r.inputs};
			4'h8: row_pick = r.contacts;
			default: row_pick = 8'h00;
		endcase
	endfunction : row_pick

	function automatic rtscmd_line_t mk_line(input rtscmd_kind_t k,
		input logic [1:0] p, input logic [31:0] d);
		mk_line = '{kind: k, port: p, data: d};
	endfunction : mk_line

	rtscmd_top_st_t s_r;
	rtscmd_top_st_t s_nxt;
	logic [15:0] mem_rdata;
	logic clr0;
	logic ret0;
	logic cmd_go;
	logic err_set;
	logic err_clr;
	logic auto_set;
	logic tmo_hit;
	logic ts_ok;
	logic [1:0] sev;
	logic [15:0] mag;
	logic [7:0] flag;

	rtscmd_mem u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(st_we),
		.waddr(st_addr),
		.wdata(st_data),
		.raddr(s_r.idx),
		.rdata(mem_rdata)
	);

	always_comb begin
		s_nxt = s_r;
		clr0 = 1'b0;
		ret0 = 1'b0;
		cmd_go = 1'b0;
		err_set = 1'b0;
		err_clr = 1'b0;
		auto_set = 1'b0;
		sev = `RTS_SEV_OK;
		mag = 16'h0000;
		flag = `RTS_CH_NONE;
		s_nxt.trig = 1'b0;
		// the route back to level 0 needs a nonzero timeout on the port
		tmo_hit = (s_r.auto_ports[0] && port_timed_out[0] &&
			s_r.port_one_idle_timeout != 8'h00) ||
			(s_r.auto_ports[1] && port_timed_out[1] &&
			s_r.port_two_idle_timeout != 8'h00);
		ts_ok = is_sep(hwdata[`RTS_TS_SEP1]) &&
			is_sep(hwdata[`RTS_TS_SEP2]) &&
			hwdata[`RTS_TS_HH] <= `RTS_HH_MAX &&
			hwdata[`RTS_TS_MM] <= `RTS_MS_MAX &&
			hwdata[`RTS_TS_SS] <= `RTS_MS_MAX;

		// ----------------------------------------
		// bus slave: zero wait states
		// ----------------------------------------
		s_nxt.dph_wr = 1'b0;
		if (hsel && htrans[1] && hready) begin
			s_nxt.dph_wr = hwrite;
			s_nxt.dph_addr = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					`RTS_A_TIME: s_nxt.hrdata = {15'h0000, s_r.tod};
					`RTS_A_AUTO: s_nxt.hrdata = {30'h0, s_r.auto_ports};
					`RTS_A_TMO1: begin
						s_nxt.hrdata = {24'h0, s_r.port_one_idle_timeout};
					end
					`RTS_A_TMO2: begin
						s_nxt.hrdata = {24'h0, s_r.port_two_idle_timeout};
					end
					`RTS_A_OFSLIM: s_nxt.hrdata = {s_r.ofs_fail, s_r.ofs_warn};
					`RTS_A_ADCLIM: s_nxt.hrdata = {16'h0000, s_r.adc_lim};
					`RTS_A_SETCK: s_nxt.hrdata = {16'h0000, s_r.set_ck};
					`RTS_A_STATUS: begin
						s_nxt.hrdata = 32'h0;
						s_nxt.hrdata[`RTS_ST_BUSY] = s_r.fsm != RTS_IDLE;
						s_nxt.hrdata[`RTS_ST_ERR] = s_r.err;
						s_nxt.hrdata[`RTS_ST_LAMP] = s_r.lamp_cnt != 24'h0;
						s_nxt.hrdata[`RTS_ST_ALARM] = s_r.alarm_contact;
						s_nxt.hrdata[`RTS_ST_LVL] = s_r.target_level_select;
					end
					`RTS_A_TGT0: s_nxt.hrdata = {24'h0, s_r.tgt0};
					`RTS_A_LED: s_nxt.hrdata = {24'h0, s_r.led};
					default: s_nxt.hrdata = 32'h0;
				endcase
			end
		end

		// ----------------------------------------
		// clock/calendar
		// ----------------------------------------
		if (irig_valid) begin
			s_nxt.tod = irig_time;
		end else if (xtal_sec_tick) begin
			if (s_r.tod.ss != `RTS_MS_MAX) begin
				s_nxt.tod.ss = s_r.tod.ss + 6'h01;
			end else begin
				s_nxt.tod.ss = 6'h00;
				if (s_r.tod.mm != `RTS_MS_MAX) begin
					s_nxt.tod.mm = s_r.tod.mm + 6'h01;
				end else begin
					s_nxt.tod.mm = 6'h00;
					if (s_r.tod.hh != `RTS_HH_MAX) begin
						s_nxt.tod.hh = s_r.tod.hh + 5'h01;
					end else begin
						s_nxt.tod.hh = 5'h00;
					end
				end
			end
		end

		// ----------------------------------------
		// register writes and commands
		// ----------------------------------------
		if (s_r.dph_wr) begin
			case (s_r.dph_addr)
				`RTS_A_CMD: begin
					if (s_r.fsm != RTS_IDLE) begin
						err_set = 1'b1;
					end else begin
						cmd_go = 1'b1;
						s_nxt.out_port = hwdata[`RTS_CMD_SRC];
						s_nxt.lv = 1'b0;
						s_nxt.hdr_cnt = 3'h0;
						s_nxt.rep_left = 8'h01;
						case (hwdata[`RTS_CMD_OP])
							`RTS_OP_STATUS: begin
								s_nxt.fsm = RTS_STAT;
								s_nxt.idx = 4'h0;
								s_nxt.fetch = 1'b1;
							end
							`RTS_OP_TARGET: begin
								if (!hwdata[`RTS_CMD_HAS_N] &&
									hwdata[`RTS_CMD_K] != 8'h00) begin
									err_set = 1'b1;
								end else if (hwdata[`RTS_CMD_N] > `RTS_LVL_MAX) begin
									err_set = 1'b1;
								end else begin
									s_nxt.fsm = RTS_HDR;
									if (hwdata[`RTS_CMD_HAS_N]) begin
										s_nxt.target_level_select =
											hwdata[`RTS_CMD_N];
									end
									if (hwdata[`RTS_CMD_HAS_N] &&
										hwdata[`RTS_CMD_K] != 8'h00) begin
										s_nxt.rep_left = hwdata[`RTS_CMD_K];
									end
								end
							end
							`RTS_OP_TGTRST: begin
								ret0 = 1'b1;
								clr0 = 1'b1;
								s_nxt.fsm = RTS_ACK;
								s_nxt.after_ack = 1'b0;
							end
							`RTS_OP_TIME: s_nxt.fsm = RTS_TIMEL;
							`RTS_OP_TRIG: begin
								s_nxt.trig = 1'b1;
								s_nxt.fsm = RTS_ACK;
								s_nxt.after_ack = 1'b1;
							end
							`RTS_OP_ACCESS2: begin
								s_nxt.alarm_cnt = 24'(ONE_SEC_CYC);
							end
							default: err_set = 1'b1;
						endcase
					end
				end
				`RTS_A_TIME: begin
					if (ts_ok) begin
						s_nxt.tod.hh = hwdata[`RTS_TS_HH];
						s_nxt.tod.mm = hwdata[`RTS_TS_MM];
						s_nxt.tod.ss = hwdata[`RTS_TS_SS];
					end else begin
						err_set = 1'b1;
					end
				end
				`RTS_A_AUTO: s_nxt.auto_ports = hwdata[1:0];
				`RTS_A_TMO1: s_nxt.port_one_idle_timeout = hwdata[7:0];
				`RTS_A_TMO2: s_nxt.port_two_idle_timeout = hwdata[7:0];
				`RTS_A_OFSLIM: begin
					s_nxt.ofs_warn = hwdata[15:0];
					s_nxt.ofs_fail = hwdata[31:16];
				end
				`RTS_A_ADCLIM: s_nxt.adc_lim = hwdata[15:0];
				`RTS_A_SETCK: s_nxt.set_ck = hwdata[15:0];
				`RTS_A_STATUS: err_clr = hwdata[`RTS_ST_ERR];
				default: begin
				end
			endcase
		end

		// ----------------------------------------
		// self-test grading
		// ----------------------------------------
		if (st_we && st_addr != `RTS_IDX_SET) begin
			mag = st_data[15] ? 16'h0000 - st_data : st_data;
			if (st_addr <= `RTS_IDX_OFS_LAST || st_addr == `RTS_IDX_MUX) begin
				if (mag >= s_r.ofs_fail) begin
					sev = `RTS_SEV_FAIL;
				end else if (mag >= s_r.ofs_warn) begin
					sev = `RTS_SEV_WARN;
				end
			end else if (st_addr == `RTS_IDX_RAM || st_addr == `RTS_IDX_ROM) begin
				// a nonzero word is the failing socket id
				sev = st_data != 16'h0000 ? `RTS_SEV_FAIL : `RTS_SEV_OK;
			end else if (st_addr == `RTS_IDX_ADC) begin
				sev = st_data > s_r.adc_lim ? `RTS_SEV_FAIL : `RTS_SEV_OK;
			end
			auto_set = sev != `RTS_SEV_OK && sev != s_r.stv[st_addr];
			s_nxt.stv[st_addr] = sev;
		end
		if (set_end) begin
			s_nxt.stv[`RTS_IDX_SET] = s_r.ck_acc != s_r.set_ck ?
				`RTS_SEV_FAIL : `RTS_SEV_OK;
			if (s_r.ck_acc != s_r.set_ck &&
				s_r.stv[`RTS_IDX_SET] != `RTS_SEV_FAIL) begin
				auto_set = 1'b1;
			end
			s_nxt.ck_acc = 16'h0000;
		end else if (set_byte_valid) begin
			s_nxt.ck_acc = s_r.ck_acc + {8'h00, set_byte};
		end

		// ----------------------------------------
		// report sequencer
		// ----------------------------------------
		case (s_r.fsm)
			RTS_IDLE: begin
				if (!cmd_go && s_r.auto_pend) begin
					s_nxt.auto_pend = 1'b0;
					if (s_r.auto_ports != 2'h0) begin
						s_nxt.fsm = RTS_STAT;
						s_nxt.out_port = s_r.auto_ports;
						s_nxt.idx = 4'h0;
						s_nxt.fetch = 1'b1;
						s_nxt.lv = 1'b0;
						if (tmo_hit) begin
							ret0 = 1'b1;
							clr0 = 1'b1;
						end
					end
				end
			end
			RTS_ACK: begin
				if (!s_r.lv) begin
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_ACK, s_r.out_port, s_r.after_ack ?
						`RTS_ACK_TRIG : `RTS_ACK_TGTRST);
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.fsm = s_r.after_ack ? RTS_SUMM : RTS_HDR;
				end
			end
			RTS_HDR: begin
				if (!s_r.lv) begin
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_HDR, s_r.out_port,
						{28'h0, s_r.target_level_select});
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.fsm = RTS_DATA;
				end
			end
			RTS_DATA: begin
				if (!s_r.lv) begin
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_DATA, s_r.out_port, {24'h0,
						row_pick(rows, s_r.target_level_select, s_r.tgt0)});
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.rep_left = s_r.rep_left - 8'h01;
					if (s_r.rep_left == 8'h01) begin
						s_nxt.fsm = RTS_IDLE;
					end else if (s_r.hdr_cnt == `RTS_HDR_LAST) begin
						s_nxt.fsm = RTS_HDR;
						s_nxt.hdr_cnt = 3'h0;
					end else begin
						s_nxt.hdr_cnt = s_r.hdr_cnt + 3'h1;
					end
				end
			end
			RTS_STAT: begin
				// one idle cycle per entry lets the store's read settle
				if (s_r.fetch) begin
					s_nxt.fetch = 1'b0;
				end else if (!s_r.lv) begin
					if (s_r.stv[s_r.idx] == `RTS_SEV_FAIL) begin
						flag = `RTS_CH_F;
					end else if (s_r.stv[s_r.idx] == `RTS_SEV_WARN) begin
						flag = `RTS_CH_W;
					end
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_STAT, s_r.out_port,
						{4'h0, s_r.idx, flag, mem_rdata});
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.fetch = 1'b1;
					s_nxt.idx = s_r.idx + 4'h1;
					if (s_r.idx == `RTS_IDX_LAST) begin
						s_nxt.fsm = RTS_IDLE;
						s_nxt.idx = 4'h0;
					end
				end
			end
			RTS_SUMM: begin
				if (!s_r.lv) begin
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_SUMM, s_r.out_port,
						{s_r.tod, 7'h00, s_r.tgt0});
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.fsm = RTS_IDLE;
				end
			end
			RTS_TIMEL: begin
				if (!s_r.lv) begin
					s_nxt.lv = 1'b1;
					s_nxt.ln = mk_line(LN_TIME, s_r.out_port,
						{15'h0000, s_r.tod});
				end else if (line_ready) begin
					s_nxt.lv = 1'b0;
					s_nxt.fsm = RTS_IDLE;
				end
			end
			default: begin
				s_nxt.fsm = RTS_IDLE;
				s_nxt.lv = 1'b0;
			end
		endcase

		// ----------------------------------------
		// targets, lamp test, alarm
		// ----------------------------------------
		if (s_r.lamp_cnt != 24'h0) begin
			s_nxt.lamp_cnt = s_r.lamp_cnt - 24'h000001;
		end
		if (tgt_reset_btn) begin
			clr0 = 1'b1;
			ret0 = 1'b1;
			s_nxt.lamp_cnt = 24'(ONE_SEC_CYC);
		end
		if (ret0) begin
			s_nxt.target_level_select = `RTS_LVL_FP;
		end
		// a target that lights in the clearing cycle is kept
		s_nxt.tgt0 = (clr0 ? 8'h00 : s_r.tgt0) | fp_target_set;
		s_nxt.auto_pend = s_nxt.auto_pend | auto_set;
		s_nxt.err = (err_clr ? 1'b0 : s_r.err) | err_set;
		if (s_r.alarm_cnt != 24'h0 && s_nxt.alarm_cnt == s_r.alarm_cnt) begin
			s_nxt.alarm_cnt = s_r.alarm_cnt - 24'h000001;
		end
		s_nxt.alarm_contact = s_nxt.alarm_cnt != 24'h0;
		s_nxt.led = s_nxt.lamp_cnt != 24'h0 ? 8'hff :
			row_pick(rows, s_nxt.target_level_select, s_nxt.tgt0);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.hrdy <= 1'b1;
			s_r.auto_ports <= `RTS_AUTO_RST;
			s_r.port_one_idle_timeout <= `RTS_TMO_RST;
			s_r.port_two_idle_timeout <= `RTS_TMO_RST;
			s_r.ofs_warn <= `RTS_OFSW_RST;
			s_r.ofs_fail <= `RTS_OFSF_RST;
			s_r.adc_lim <= `RTS_ADCLIM_RST;
			s_r.set_ck <= `RTS_SETCK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hrdy;
	assign hresp = s_r.hresp;
	assign line_valid = s_r.lv;
	assign line = s_r.ln;
	assign target_led = s_r.led;
	assign alarm_contact = s_r.alarm_contact;
	assign event_trig = s_r.trig;
endmodule : rtscmd_top

//--- rtl/rtscmd_params.svh
`ifndef RTSCMD_PARAMS_SVH
`define RTSCMD_PARAMS_SVH
// Notes on behaviour
// - a self-test entering warning or failure raises a status report unprompted.
// - unprompted status reports go only to ports set as automatic.
// - report shows seven channel offsets, out-of-tolerance ones tagged W or F.
// - report shows the three supply voltages.
// - failed RAM or ROM entry shows the socket id instead of OK.
// - converter test checks conversion time; mux test checks path offset.
// - settings test sums stored settings and compares to saved checksum.
// - after power-up the LEDs show front-panel targets, level 0.
// - target command routes one of nine 8-bit sets to the LEDs.
// - each target bit is 1 when asserted, 0 when deasserted.
// - repeat count prints the row that often; needs a row number.
// - column headings are reprinted after every eight data lines.
// - auto message to a timed-out port clears targets, returns level 0.
// - reset button clears level 0 targets and lamps all LEDs one second.
// - no return to level 0 for zero-timeout ports or both timeouts zero.
// - target reset goes to level 0, clears, confirms, prints level 0 row.
// - time command shows the clock; set accepts : ; space , / separators.
// - clock counts crystal seconds and can load from a time code input.
// - trigger makes an event record, acknowledges, prints a summary.
// - any top access level attempt closes the alarm contact one second; here only if the sequencer is idle, else it just sets the error flag.

`define RTS_CLK_HZ 10000000
`define RTS_ONE_SEC_MS 1000

`define RTS_A_CMD 8'h00
`define RTS_A_TIME 8'h04
`define RTS_A_AUTO 8'h08
`define RTS_A_TMO1 8'h0c
`define RTS_A_TMO2 8'h10
`define RTS_A_OFSLIM 8'h14
`define RTS_A_ADCLIM 8'h18
`define RTS_A_SETCK 8'h1c
`define RTS_A_STATUS 8'h20
`define RTS_A_TGT0 8'h24
`define RTS_A_LED 8'h28

`define RTS_OP_STATUS 4'h1
`define RTS_OP_TARGET 4'h2
`define RTS_OP_TGTRST 4'h3
`define RTS_OP_TIME 4'h4
`define RTS_OP_TRIG 4'h5
`define RTS_OP_ACCESS2 4'h6
`define RTS_CMD_OP 3:0
`define RTS_CMD_N 7:4
`define RTS_CMD_HAS_N 8
`define RTS_CMD_K 23:16
`define RTS_CMD_SRC 25:24

`define RTS_TS_HH 4:0
`define RTS_TS_MM 10:5
`define RTS_TS_SS 16:11
`define RTS_TS_SEP1 23:17
`define RTS_TS_SEP2 30:24
`define RTS_SEP_COLON 7'h3a
`define RTS_SEP_SEMI 7'h3b
`define RTS_SEP_SPACE 7'h20
`define RTS_SEP_COMMA 7'h2c
`define RTS_SEP_SLASH 7'h2f
`define RTS_HH_MAX 5'h17
`define RTS_MS_MAX 6'h3b

`define RTS_LVL_FP 4'h0
`define RTS_LVL_MAX 4'h8
`define RTS_HDR_LAST 3'h7

`define RTS_IDX_OFS_LAST 4'h6
`define RTS_IDX_RAM 4'ha
`define RTS_IDX_ROM 4'hb
`define RTS_IDX_ADC 4'hc
`define RTS_IDX_MUX 4'hd
`define RTS_IDX_SET 4'he
`define RTS_IDX_LAST 4'he
`define RTS_SEV_OK 2'h0
`define RTS_SEV_WARN 2'h1
`define RTS_SEV_FAIL 2'h2
`define RTS_CH_W 8'h57
`define RTS_CH_F 8'h46
`define RTS_CH_NONE 8'h00

`define RTS_ACK_TGTRST 32'h00000001
`define RTS_ACK_TRIG 32'h00000002
`define RTS_ST_BUSY 0
`define RTS_ST_ERR 1
`define RTS_ST_LAMP 2
`define RTS_ST_ALARM 3
`define RTS_ST_LVL 7:4

`define RTS_AUTO_RST 2'h1
`define RTS_TMO_RST 8'h00
`define RTS_OFSW_RST 16'hffff
`define RTS_OFSF_RST 16'hffff
`define RTS_ADCLIM_RST 16'hffff
`define RTS_SETCK_RST 16'h0000
`endif

//--- rtl/rtscmd_pkg.sv
package rtscmd_pkg;
	typedef enum logic [2:0] {
		RTS_IDLE = 3'h0, RTS_ACK = 3'h1, RTS_HDR = 3'h3, RTS_DATA = 3'h2,
		RTS_STAT = 3'h6, RTS_SUMM = 3'h7, RTS_TIMEL = 3'h5
	} rtscmd_state_t;
	typedef enum logic [2:0] {
		LN_HDR = 3'h0, LN_DATA = 3'h1, LN_ACK = 3'h2,
		LN_STAT = 3'h3, LN_SUMM = 3'h4, LN_TIME = 3'h5
	} rtscmd_kind_t;
	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} rtscmd_time_t;
	typedef struct packed {
		rtscmd_kind_t kind;
		logic [1:0] port;
		logic [31:0] data;
	} rtscmd_line_t;
	typedef struct packed {
		logic [5:0][7:0] relay_word;
		logic [5:0] inputs;
		logic [7:0] contacts;
	} rtscmd_rows_t;
	typedef struct packed {
		logic [15:0][15:0] words;
		logic [15:0] rdata;
	} rtscmd_mem_st_t;
	typedef struct packed {
		rtscmd_state_t fsm;
		logic dph_wr;
		logic [7:0] dph_addr;
		logic [31:0] hrdata;
		logic hrdy;
		logic hresp;
		logic [3:0] target_level_select;
		logic [7:0] tgt0;
		logic [7:0] led;
		logic [23:0] lamp_cnt;
		logic [23:0] alarm_cnt;
		logic alarm_contact;
		logic trig;
		rtscmd_time_t tod;
		logic [1:0] auto_ports;
		logic [7:0] port_one_idle_timeout;
		logic [7:0] port_two_idle_timeout;
		logic [15:0] ofs_warn;
		logic [15:0] ofs_fail;
		logic [15:0] adc_lim;
		logic [15:0] set_ck;
		logic [15:0] ck_acc;
		logic [15:0][1:0] stv;
		logic auto_pend;
		logic err;
		logic [7:0] rep_left;
		logic [2:0] hdr_cnt;
		logic [3:0] idx;
		logic fetch;
		logic after_ack;
		logic [1:0] out_port;
		logic lv;
		rtscmd_line_t ln;
	} rtscmd_top_st_t;
endpackage : rtscmd_pkg

//--- rtl/rtscmd_mem.sv
`timescale 1ns/100ps
// ----------------------------------------
// self-test result store, registered read
// ----------------------------------------
module rtscmd_mem import rtscmd_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [3:0] raddr,
	output logic [15:0] rdata
);
	rtscmd_mem_st_t s_r;
	rtscmd_mem_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (we) begin
			s_nxt.words[waddr] = wdata;
		end
		s_nxt.rdata = s_r.words[raddr];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
endmodule : rtscmd_mem

//--- tb/rtscmd_chk.sv
`timescale 1ns/100ps
module rtscmd_chk import rtscmd_pkg::*; #(
	parameter int unsigned ONE_SEC_CYC = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic tgt_reset_btn,
	input wire logic line_valid,
	input wire logic line_ready,
	input wire rtscmd_line_t line,
	input wire logic [7:0] target_led,
	input wire logic alarm_contact,
	input wire logic event_trig
);
	// margin of one cycle so the lamp end is judged once it has settled
	localparam int LAMP_END = ONE_SEC_CYC + 2;
	logic [31:0] alm_cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alm_cnt_r <= 32'h0;
		end else begin
			alm_cnt_r <= alarm_contact ? alm_cnt_r + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	okay_resp_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	line_hold_a: assert property (line_valid && !line_ready |=>
		line_valid && $stable(line)) else $error("line dropped early");
	lamp_on_a: assert property (tgt_reset_btn |=>
		(target_led == 8'hff) [*8]) else $error("lamp test missing");
	lamp_off_a: assert property (tgt_reset_btn |->
		##LAMP_END target_led != 8'hff) else $error("lamp test too long");
	alarm_len_a: assert property ($fell(alarm_contact) |->
		alm_cnt_r == ONE_SEC_CYC) else $error("alarm pulse length");
	alarm_max_a: assert property (alm_cnt_r <= ONE_SEC_CYC)
		else $error("alarm held too long");
	trig_pulse_a: assert property (event_trig |=> !event_trig)
		else $error("event request not one cycle");
	trig_ack_a: assert property (event_trig |-> ##[0:4]
		(line_valid && line.kind == LN_ACK && line.data == 32'h2))
		else $error("no trigger acknowledge");
endmodule : rtscmd_chk
bind rtscmd_top rtscmd_chk #(.ONE_SEC_CYC(ONE_SEC_CYC)) rtscmd_chk_i (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.tgt_reset_btn(tgt_reset_btn), .line_valid(line_valid),
	.line_ready(line_ready), .line(line), .target_led(target_led),
	.alarm_contact(alarm_contact), .event_trig(event_trig));

//--- tb/rtscmd_sink.sv
`timescale 1ns/100ps
// ----------------------------------------
// terminal side: collects lines, may stall
// ----------------------------------------
module rtscmd_sink import rtscmd_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic stall,
	input wire logic line_valid,
	input wire rtscmd_line_t line,
	output logic line_ready
);
	rtscmd_line_t q[$];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			line_ready <= 1'b0;
		end else begin
			if (line_valid && line_ready) begin
				q.push_back(line);
			end
			line_ready <= !stall;
		end
	end
endmodule : rtscmd_sink

//--- tb/tb_relay_target_status_cmds.sv
`timescale 1ns/100ps
module tb_relay_target_status_cmds import rtscmd_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, line_valid;
	logic line_ready, alarm_contact, event_trig, tgt_reset_btn, stall;
	logic xtal_sec_tick, irig_valid, st_we, set_byte_valid, set_end;
	logic [31:0] haddr, hwdata, hrdata, rd_v;
	logic [1:0] htrans, port_timed_out;
	logic [2:0] hsize;
	logic [7:0] fp_target_set, target_led, set_byte, t0;
	logic [3:0] st_addr;
	logic [15:0] st_data;
	logic [6:0] sep [5] = '{7'h3a, 7'h3b, 7'h20, 7'h2c, 7'h2f};
	rtscmd_rows_t rows;
	rtscmd_time_t irig_time;
	rtscmd_line_t line, l;
	int errors, n_compared, i, j, n;
	rtscmd_top #(.ONE_SEC_CYC(20)) rtscmd_top_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rows(rows),
		.fp_target_set(fp_target_set), .tgt_reset_btn(tgt_reset_btn),
		.port_timed_out(port_timed_out), .xtal_sec_tick(xtal_sec_tick),
		.irig_valid(irig_valid), .irig_time(irig_time), .st_we(st_we),
		.st_addr(st_addr), .st_data(st_data), .set_byte(set_byte),
		.set_byte_valid(set_byte_valid), .set_end(set_end),
		.line_ready(line_ready), .line_valid(line_valid), .line(line),
		.target_led(target_led), .alarm_contact(alarm_contact),
		.event_trig(event_trig));
	rtscmd_sink rtscmd_sink_i (.hclk(hclk), .hresetn(hresetn), .stall(stall),
		.line_valid(line_valid), .line(line), .line_ready(line_ready));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		#2000000;
		errors++;
		finish_test();
	end
	task finish_test;
		$display("compared %0d, wrong %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_v = hrdata;
		hsel <= 1'b0;
		@(posedge hclk);
	endtask : bus
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask : rdc
	task take(input int k);
		for (n = 0; n < 3000 && rtscmd_sink_i.q.size() < k; n++) @(posedge hclk);
		chk(32'(rtscmd_sink_i.q.size()), 32'(k));
	endtask : take
	task chkl(input rtscmd_kind_t k, input logic [31:0] d);
		l = rtscmd_sink_i.q.pop_front();
		chk({29'h0, l.kind}, {29'h0, k});
		chk(l.data, d);
	endtask : chkl
	function logic [7:0] row(input logic [3:0] lv);
		case (lv)
			4'h0: row = t0;
			4'h7: row = {2'h0, rows.inputs};
			4'h8: row = rows.contacts;
			default: row = rows.relay_word[lv - 4'h1];
		endcase
	endfunction : row
	task tgt(input logic [3:0] lv);
		bus(1'b1, 8'h00, {6'h0, 2'h1, 8'h0, 7'h0, 1'b1, lv, 4'h2});
		take(2);
		chkl(LN_HDR, {28'h0, lv});
		chkl(LN_DATA, {24'h0, row(lv)});
		repeat (2) @(posedge hclk);
	endtask : tgt
	task stw(input logic [3:0] a, input logic [15:0] d);
		st_we <= 1'b1;
		st_addr <= a;
		st_data <= d;
		@(posedge hclk);
		st_we <= 1'b0;
	endtask : stw
	task stat(input logic [1:0] p, input logic [3:0] ix, input logic [31:0] d);
		take(15);
		for (i = 0; i < 15; i++) begin
			l = rtscmd_sink_i.q.pop_front();
			chk({27'h0, l.kind, l.port}, {27'h0, LN_STAT, p});
			if (i == ix) chk(l.data, d);
			if (i == 7) chk(l.data, 32'h0700_000c);
		end
		repeat (2) @(posedge hclk);
	endtask : stat
	initial begin
		{hresetn, hsel, hwrite, tgt_reset_btn, stall, xtal_sec_tick} = 6'h0;
		{irig_valid, st_we, set_byte_valid, set_end} = 4'h0;
		{haddr, hwdata, htrans, port_timed_out, st_addr, st_data} = 88'h0;
		{fp_target_set, set_byte, irig_time, t0} = 41'h0;
		hsize = 3'h2;
		rows = {8'h66, 8'h55, 8'h44, 8'h33, 8'h0b, 8'h11, 6'h2a, 8'hc5};
		errors = 0;
		n_compared = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(8'h28, 32'h0);
		rdc(8'h20, 32'h0);
		rdc(8'h08, 32'h1);
		rdc(8'h3c, 32'h0);
		fp_target_set <= 8'h81;
		@(posedge hclk);
		fp_target_set <= 8'h0;
		t0 = 8'h81;
		rdc(8'h24, 32'h81);
		for (j = 0; j < 9; j++) begin
			tgt(j[3:0]);
			rdc(8'h28, {24'h0, row(j[3:0])});
			rdc(8'h20, {24'h0, j[3:0], 4'h0});
		end
		stall <= 1'b1;
		bus(1'b1, 8'h00, {6'h0, 2'h1, 8'd10, 8'h1, 8'h32});
		repeat (10) @(posedge hclk);
		stall <= 1'b0;
		take(12);
		for (j = 0; j < 12; j++) begin
			if (j == 0 || j == 9) begin
				chkl(LN_HDR, 32'h3);
			end else begin
				chkl(LN_DATA, 32'h33);
			end
		end
		repeat (2) @(posedge hclk);
		bus(1'b1, 8'h00, 32'h0102_0002);
		rdc(8'h20, 32'h32);
		bus(1'b1, 8'h20, 32'h2);
		bus(1'b1, 8'h00, 32'h0100_0192);
		rdc(8'h20, 32'h32);
		bus(1'b1, 8'h20, 32'h2);
		bus(1'b1, 8'h00, 32'h0100_0003);
		take(3);
		t0 = 8'h0;
		chkl(LN_ACK, 32'h1);
		chkl(LN_HDR, 32'h0);
		chkl(LN_DATA, 32'h0);
		repeat (2) @(posedge hclk);
		rdc(8'h24, 32'h0);
		rdc(8'h20, 32'h0);
		tgt(4'h5);
		tgt_reset_btn <= 1'b1;
		@(posedge hclk);
		tgt_reset_btn <= 1'b0;
		rdc(8'h28, 32'hff);
		repeat (25) @(posedge hclk);
		rdc(8'h28, 32'h0);
		rdc(8'h20, 32'h0);
		bus(1'b1, 8'h0c, 32'h5);
		bus(1'b1, 8'h14, 32'h0020_0008);
		port_timed_out <= 2'h1;
		stw(4'h7, 16'hc);
		tgt(4'h4);
		stw(4'ha, 16'h5);
		stat(2'h1, 4'ha, 32'h0a46_0005);
		rdc(8'h20, 32'h0);
		bus(1'b1, 8'h0c, 32'h0);
		tgt(4'h4);
		stw(4'h0, 16'h10);
		stat(2'h1, 4'h0, 32'h0057_0010);
		rdc(8'h20, 32'h40);
		bus(1'b1, 8'h00, 32'h0200_0001);
		stat(2'h2, 4'ha, 32'h0a46_0005);
		bus(1'b1, 8'h18, 32'h10);
		stw(4'hc, 16'h11);
		stat(2'h1, 4'hc, 32'h0c46_0011);
		set_byte <= 8'h12;
		set_byte_valid <= 1'b1;
		@(posedge hclk);
		set_byte_valid <= 1'b0;
		set_end <= 1'b1;
		@(posedge hclk);
		set_end <= 1'b0;
		stat(2'h1, 4'he, 32'h0e46_0000);
		for (j = 0; j < 5; j++) begin
			bus(1'b1, 8'h04, {1'b0, sep[j], sep[j], 6'h0, 6'h1e, 5'h17});
			rdc(8'h04, {15'h0, 5'h17, 6'h1e, 6'h0});
		end
		bus(1'b1, 8'h04, {1'b0, 7'h2d, 7'h3a, 17'h0});
		rdc(8'h20, 32'h42);
		bus(1'b1, 8'h20, 32'h2);
		xtal_sec_tick <= 1'b1;
		@(posedge hclk);
		xtal_sec_tick <= 1'b0;
		rdc(8'h04, {15'h0, 5'h17, 6'h1e, 6'h1});
		irig_time <= {5'h1, 6'h2, 6'h3};
		irig_valid <= 1'b1;
		@(posedge hclk);
		irig_valid <= 1'b0;
		rdc(8'h04, 32'h1083);
		bus(1'b1, 8'h00, 32'h0100_0004);
		take(1);
		chkl(LN_TIME, 32'h1083);
		bus(1'b1, 8'h00, 32'h0100_0005);
		take(2);
		chkl(LN_ACK, 32'h2);
		l = rtscmd_sink_i.q.pop_front();
		chk({29'h0, l.kind}, {29'h0, LN_SUMM});
		bus(1'b1, 8'h00, 32'h0100_0006);
		rdc(8'h20, 32'h48);
		repeat (25) @(posedge hclk);
		rdc(8'h20, 32'h40);
		finish_test();
	end
endmodule : tb_relay_target_status_cmds
